// ---- verilog/modulator_source_select.sv ----
// top: modulation and high carrier source selection with carrier switch logic
// assumes: peripheral outputs and low carrier share ref_clk; pins and oscillators are asynchronous
//
// Operation
// - modulation selector reads zero in bits 7-5; only five low bits stored.
// - modulation code picks pin, software level, peripherals up to 11010; rest reserved.
// - high carrier code picks pin, system clock, oscillator, peripherals to 10010.
// - unsynchronised carrier switching may truncate pulses; modelled, not suppressed.
// - both selectors read/write; undefined after power-on (loaded as 00000 here), kept across other resets.
// - software level one passes high carrier, zero passes low carrier.
// - with sync enabled, wait for high carrier falling edge before going low.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module modulator_source_select #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic clk_en,
  input wire logic [modsel_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [modsel_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [modsel_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic modulation_pin_route,
  input wire logic carrier_pin_route,
  input wire logic system_clock_source,
  input wire logic fast_internal_oscillator,
  input wire logic serial_transmit_output,
  input wire logic usart_sync_data,
  input wire logic spi_data_output,
  input wire logic [3:0] capture_compare_output,
  input wire logic [8:0] pwm_output,
  input wire logic [3:0] logic_cell_output,
  input wire logic [5:0] synchronized_comparator_output,
  input wire logic low_carrier,
  output logic modulated_out
);
  logic [modsel_pkg::SEL_W-1:0] modulation_source_field;
  logic [modsel_pkg::SEL_W-1:0] next_modulation_source_field;
  logic [modsel_pkg::SEL_W-1:0] high_carrier_select_field;
  logic [modsel_pkg::SEL_W-1:0] next_high_carrier_select_field;
  logic software_modulation_level;
  logic next_software_modulation_level;
  logic high_carrier_sync_enable;
  logic next_high_carrier_sync_enable;
  logic ack;
  logic next_ack;
  logic [modsel_pkg::DATA_W-1:0] next_readdata;
  logic [3:0] async_in;
  logic [3:0] sync_first;
  logic [3:0] sync_second;
  logic mod_pin_s;
  logic car_pin_s;
  logic sysclk_s;
  logic fast_osc_s;
  logic [modsel_pkg::SRC_N-1:0] mod_sources;
  logic [modsel_pkg::SRC_N-1:0] car_sources;
  logic mod_level;
  logic high_level;
  logic high_level_prev;
  modsel_pkg::mod_state_t state;
  modsel_pkg::mod_state_t next_state;
  logic next_modulated_out;
  logic req;
  logic take;
  logic bus_write;
  logic hit_mod_src;
  logic hit_high_car;
  logic hit_control;
  logic hit_status;
  logic [modsel_pkg::DATA_W-1:0] read_value;
  logic [3:0] next_sync_first;
  logic [3:0] next_sync_second;

  sel_if mod_sel ();
  sel_if car_sel ();

  // asynchronous pins and clocks pass two flops before any use
  assign async_in = {fast_internal_oscillator, system_clock_source, carrier_pin_route, modulation_pin_route};

  always_comb begin
    next_sync_first = sync_first;
    next_sync_second = sync_second;
    if (clk_en) begin
      next_sync_first = async_in;
      next_sync_second = sync_first;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync_first <= 4'h0;
      sync_second <= 4'h0;
    end else begin
      sync_first <= next_sync_first;
      sync_second <= next_sync_second;
    end
  end

  assign mod_pin_s = sync_second[0];
  assign car_pin_s = sync_second[1];
  assign sysclk_s = sync_second[2];
  assign fast_osc_s = sync_second[3];

  // modulation source vector, index equals selector code
  always_comb begin
    mod_sources = '0;
    mod_sources[modsel_pkg::MOD_PIN] = mod_pin_s;
    mod_sources[modsel_pkg::MOD_LEVEL] = software_modulation_level;
    mod_sources[modsel_pkg::MOD_TX] = serial_transmit_output;
    mod_sources[modsel_pkg::MOD_SYNC_DATA] = usart_sync_data;
    mod_sources[modsel_pkg::MOD_SDO] = spi_data_output;
    mod_sources[modsel_pkg::MOD_CCP +: 3] = capture_compare_output[2:0];
    // pwm order at codes 01000 up: 8,3,4,9,10,5,6,11,12
    mod_sources[modsel_pkg::MOD_PWM +: 9] = {pwm_output[8], pwm_output[7], pwm_output[3],
                                            pwm_output[2], pwm_output[6], pwm_output[5],
                                            pwm_output[1], pwm_output[0], pwm_output[4]};
    mod_sources[modsel_pkg::MOD_LC +: 4] = logic_cell_output;
    mod_sources[modsel_pkg::MOD_CMP +: 6] = synchronized_comparator_output;
  end

  // high carrier source vector, index equals selector code
  always_comb begin
    car_sources = '0;
    car_sources[modsel_pkg::CAR_PIN] = car_pin_s;
    car_sources[modsel_pkg::CAR_SYSCLK] = sysclk_s;
    car_sources[modsel_pkg::CAR_FAST_OSC] = fast_osc_s;
    car_sources[modsel_pkg::CAR_CCP +: 4] = capture_compare_output;
    // pwm order at codes 00111 up: 3,4,9,10,5,6,11,12
    car_sources[modsel_pkg::CAR_PWM +: 8] = {pwm_output[8], pwm_output[7], pwm_output[3],
                                            pwm_output[2], pwm_output[6], pwm_output[5],
                                            pwm_output[1], pwm_output[0]};
    car_sources[modsel_pkg::CAR_LC +: 4] = logic_cell_output;
  end

  assign mod_sel.code = modulation_source_field;
  assign mod_sel.sources = mod_sources;
  assign mod_sel.reserved = SMALL_VARIANT ? modsel_pkg::MOD_RSVD_SMALL : modsel_pkg::MOD_RSVD_FULL;
  assign car_sel.code = high_carrier_select_field;
  assign car_sel.sources = car_sources;
  assign car_sel.reserved = SMALL_VARIANT ? modsel_pkg::CAR_RSVD_SMALL : modsel_pkg::CAR_RSVD_FULL;

  source_mux u_mod_mux (
    .sel(mod_sel.chooser)
  );

  source_mux u_car_mux (
    .sel(car_sel.chooser)
  );

  assign mod_level = mod_sel.selected;
  assign high_level = car_sel.selected;

  // avalon-mm slave: one wait cycle, then the access completes
  // a low clock enable keeps waitrequest up, so no access completes unseen
  assign req = read | write;
  assign take = req & ack & clk_en;
  assign waitrequest = req & ~take;
  assign bus_write = take & write & byteenable[0];

  // address decode; unmapped or misaligned offsets hit nothing
  always_comb begin
    hit_mod_src = 1'b0;
    hit_high_car = 1'b0;
    hit_control = 1'b0;
    hit_status = 1'b0;
    if (address == modsel_pkg::OFS_MOD_SRC) begin
      hit_mod_src = 1'b1;
    end else if (address == modsel_pkg::OFS_HIGH_CAR) begin
      hit_high_car = 1'b1;
    end else if (address == modsel_pkg::OFS_CONTROL) begin
      hit_control = 1'b1;
    end else if (address == modsel_pkg::OFS_STATUS) begin
      hit_status = 1'b1;
    end
  end

  // read value kept apart from the handshake; unused bits read zero
  always_comb begin
    read_value = '0;
    if (hit_mod_src) begin
      read_value[modsel_pkg::SEL_W-1:0] = modulation_source_field;
    end else if (hit_high_car) begin
      read_value[modsel_pkg::SEL_W-1:0] = high_carrier_select_field;
    end else if (hit_control) begin
      read_value[modsel_pkg::CTL_LEVEL_BIT] = software_modulation_level;
      read_value[modsel_pkg::CTL_SYNC_BIT] = high_carrier_sync_enable;
    end else if (hit_status) begin
      read_value[modsel_pkg::STS_OUT_BIT] = modulated_out;
      read_value[modsel_pkg::STS_MOD_BIT] = mod_level;
      read_value[modsel_pkg::STS_HIGH_BIT] = high_level;
      read_value[modsel_pkg::STS_WAIT_BIT] = (state == modsel_pkg::ST_WAIT_FALL);
    end
  end

  always_comb begin
    next_ack = ack;
    next_readdata = readdata;
    next_modulation_source_field = modulation_source_field;
    next_high_carrier_select_field = high_carrier_select_field;
    next_software_modulation_level = software_modulation_level;
    next_high_carrier_sync_enable = high_carrier_sync_enable;
    if (req && !ack) begin
      next_ack = 1'b1;
      if (read) begin
        next_readdata = read_value;
      end else begin
        next_readdata = '0;
      end
    end else begin
      next_ack = 1'b0;
    end
    if (bus_write) begin
      // upper bits of byte 0 are dropped, only the field is kept
      if (hit_mod_src) begin
        next_modulation_source_field = writedata[modsel_pkg::SEL_W-1:0];
      end else if (hit_high_car) begin
        next_high_carrier_select_field = writedata[modsel_pkg::SEL_W-1:0];
      end else if (hit_control) begin
        next_software_modulation_level = writedata[modsel_pkg::CTL_LEVEL_BIT];
        next_high_carrier_sync_enable = writedata[modsel_pkg::CTL_SYNC_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack <= 1'b0;
      readdata <= '0;
      software_modulation_level <= modsel_pkg::CTL_RESET[modsel_pkg::CTL_LEVEL_BIT];
      high_carrier_sync_enable <= modsel_pkg::CTL_RESET[modsel_pkg::CTL_SYNC_BIT];
    end else if (clk_en) begin
      ack <= next_ack;
      readdata <= next_readdata;
      software_modulation_level <= next_software_modulation_level;
      high_carrier_sync_enable <= next_high_carrier_sync_enable;
    end
  end

  // selectors ignore the ordinary reset and only reload on power-on
  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      modulation_source_field <= modsel_pkg::SEL_POR_VALUE;
      high_carrier_select_field <= modsel_pkg::SEL_POR_VALUE;
    end else if (clk_en) begin
      modulation_source_field <= next_modulation_source_field;
      high_carrier_select_field <= next_high_carrier_select_field;
    end
  end

  // carrier switching: high while modulation is one or a sync wait for the high carrier fall is pending, low otherwise
  always_comb begin
    next_state = state;
    case (state)
      modsel_pkg::ST_LOW: begin
        if (mod_level) begin
          next_state = modsel_pkg::ST_HIGH;
        end
      end
      modsel_pkg::ST_HIGH: begin
        if (!mod_level) begin
          // without sync the high pulse is cut where it stands
          if (high_carrier_sync_enable && high_level) begin
            next_state = modsel_pkg::ST_WAIT_FALL;
          end else begin
            next_state = modsel_pkg::ST_LOW;
          end
        end
      end
      modsel_pkg::ST_WAIT_FALL: begin
        if (mod_level) begin
          next_state = modsel_pkg::ST_HIGH;
        end else if (!high_carrier_sync_enable) begin
          // sync dropped mid-wait: cut the pulse as an unsynchronised switch would
          next_state = modsel_pkg::ST_LOW;
        end else if (high_level_prev && !high_level) begin
          next_state = modsel_pkg::ST_LOW;
        end
      end
      default: begin
        next_state = modsel_pkg::ST_LOW;
      end
    endcase
    if (next_state == modsel_pkg::ST_LOW) begin
      next_modulated_out = low_carrier;
    end else begin
      // the pulse in flight finishes on the high carrier
      next_modulated_out = high_level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= modsel_pkg::ST_LOW;
      high_level_prev <= 1'b0;
      modulated_out <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      high_level_prev <= high_level;
      modulated_out <= next_modulated_out;
    end
  end
endmodule

// ---- verilog/modsel_pkg.sv ----
// package: offsets, field layout, codes and states of the modulator source select
// assumes: single clock domain, avalon-mm register access with byte addressing
package modsel_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int SEL_W = 5;
  localparam int SRC_N = 32;
  localparam logic [ADDR_W-1:0] OFS_MOD_SRC = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_HIGH_CAR = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
  // control register fields
  localparam int CTL_LEVEL_BIT = 0;
  localparam int CTL_SYNC_BIT = 1;
  // status register fields
  localparam int STS_OUT_BIT = 0;
  localparam int STS_MOD_BIT = 1;
  localparam int STS_HIGH_BIT = 2;
  localparam int STS_WAIT_BIT = 3;
  // selector value loaded on power-on / brown-out; true hardware leaves it unknown
  localparam logic [SEL_W-1:0] SEL_POR_VALUE = 5'h00;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam int SYNC_STAGES = 2;
  // modulation source codes
  localparam logic [SEL_W-1:0] MOD_PIN = 5'h00;
  localparam logic [SEL_W-1:0] MOD_LEVEL = 5'h01;
  localparam logic [SEL_W-1:0] MOD_TX = 5'h02;
  localparam logic [SEL_W-1:0] MOD_SYNC_DATA = 5'h03;
  localparam logic [SEL_W-1:0] MOD_SDO = 5'h04;
  localparam logic [SEL_W-1:0] MOD_CCP = 5'h05;
  localparam logic [SEL_W-1:0] MOD_PWM = 5'h08;
  localparam logic [SEL_W-1:0] MOD_LC = 5'h11;
  localparam logic [SEL_W-1:0] MOD_CMP = 5'h15;
  localparam logic [SEL_W-1:0] MOD_FIRST_RSVD = 5'h1b;
  // high carrier source codes
  localparam logic [SEL_W-1:0] CAR_PIN = 5'h00;
  localparam logic [SEL_W-1:0] CAR_SYSCLK = 5'h01;
  localparam logic [SEL_W-1:0] CAR_FAST_OSC = 5'h02;
  localparam logic [SEL_W-1:0] CAR_CCP = 5'h03;
  localparam logic [SEL_W-1:0] CAR_PWM = 5'h07;
  localparam logic [SEL_W-1:0] CAR_LC = 5'h0f;
  localparam logic [SEL_W-1:0] CAR_FIRST_RSVD = 5'h13;
  // reserved masks: full variant and the smaller variant
  localparam logic [SRC_N-1:0] MOD_RSVD_FULL = 32'hf800_0000;
  localparam logic [SRC_N-1:0] MOD_RSVD_SMALL = 32'hf801_1100;
  localparam logic [SRC_N-1:0] CAR_RSVD_FULL = 32'hfff8_0000;
  localparam logic [SRC_N-1:0] CAR_RSVD_SMALL = 32'hfff8_4440;
  typedef enum logic [2:0] {
    ST_LOW = 3'h1,
    ST_HIGH = 3'h2,
    ST_WAIT_FALL = 3'h4
  } mod_state_t;
endpackage

// ---- verilog/sel_if.sv ----
// interface: one source selector, code and source vector in, chosen level out
// assumes: driven and consumed on the same clock by the top module
`timescale 1ns/100ps
interface sel_if;
  logic [modsel_pkg::SEL_W-1:0] code;
  logic [modsel_pkg::SRC_N-1:0] sources;
  logic [modsel_pkg::SRC_N-1:0] reserved;
  logic selected;
  modport chooser (input code, input sources, input reserved, output selected);
  modport user (output code, output sources, output reserved, input selected);
endinterface

// ---- verilog/source_mux.sv ----
// module: picks one level out of a 32-entry source vector by a 5-bit code
// assumes: reserved mask marks codes that must read as a constant low
`timescale 1ns/100ps
module source_mux (
  sel_if.chooser sel
);
  localparam int CODE_W = modsel_pkg::SEL_W;
  logic [modsel_pkg::SRC_N-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < modsel_pkg::SRC_N; i = i + 1) begin : g_hit
      // reserved codes never pass their source through
      assign hit[i] = (sel.code == CODE_W'(i)) & sel.sources[i] & ~sel.reserved[i];
    end
  endgenerate

  assign sel.selected = |hit;
endmodule

// ---- tb/modulator_source_select_checker.sv ----
// checker: bus handshake, selector readback and modulator output relations
// assumes: bound to the top module; control shadow follows the control register layout
`timescale 1ns/100ps
module modulator_source_select_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic clk_en,
  input wire logic [modsel_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [modsel_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [modsel_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [3:0] capture_compare_output,
  input wire logic low_carrier,
  input wire logic modulated_out
);
  logic [4:0] mod_sh;
  logic [4:0] car_sh;
  logic [1:0] ctl_sh;
  logic [4:0] next_mod_sh;
  logic [4:0] next_car_sh;
  logic [1:0] next_ctl_sh;
  logic wr_ok;
  logic lvl_mode;
  assign wr_ok = write && !waitrequest && clk_en && byteenable[0];
  assign lvl_mode = mod_sh == modsel_pkg::MOD_LEVEL && car_sh == modsel_pkg::CAR_CCP;
  // selectors ignore the ordinary reset, so only power-on clears the selector shadows; reset clears the control shadow
  always_comb begin
    next_mod_sh = mod_sh;
    next_car_sh = car_sh;
    next_ctl_sh = reset_n ? ctl_sh : modsel_pkg::CTL_RESET;
    if (wr_ok && address == modsel_pkg::OFS_MOD_SRC) next_mod_sh = writedata[4:0];
    if (wr_ok && address == modsel_pkg::OFS_HIGH_CAR) next_car_sh = writedata[4:0];
    if (wr_ok && reset_n && address == modsel_pkg::OFS_CONTROL) next_ctl_sh = writedata[1:0];
    if (!por_n) begin
      next_mod_sh = modsel_pkg::SEL_POR_VALUE;
      next_car_sh = modsel_pkg::SEL_POR_VALUE;
    end
  end
  always_ff @(posedge ref_clk) begin
    mod_sh <= next_mod_sh;
    car_sh <= next_car_sh;
    ctl_sh <= next_ctl_sh;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_bus_start: assert property ($rose(read || write) |-> waitrequest)
    else $error("request answered without a wait cycle");
  a_bus_one_wait: assert property ((read || write) && waitrequest && clk_en ##1 clk_en |-> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_freeze_wait: assert property ((read || write) && !clk_en |-> waitrequest)
    else $error("request completed while the block was frozen");
  a_upper_zero: assert property (read && !waitrequest && address inside {4'h0, 4'h4} |-> readdata[31:5] == 27'h0)
    else $error("selector upper bits read nonzero");
  a_mod_readback: assert property (read && !waitrequest && address == 4'h0 |-> readdata[4:0] == mod_sh)
    else $error("modulation selector readback differs");
  a_car_readback: assert property (read && !waitrequest && address == 4'h4 |-> readdata[4:0] == car_sh)
    else $error("high carrier selector readback differs");
  a_level_low: assert property ((ctl_sh == 2'h0 && mod_sh == modsel_pkg::MOD_LEVEL) [*3]
    |=> modulated_out == $past(low_carrier)) else $error("level zero did not pass low carrier");
  a_level_high: assert property ((ctl_sh == 2'h1 && lvl_mode) [*3]
    |=> modulated_out == $past(capture_compare_output[0])) else $error("level one did not pass high carrier");
  a_rsvd_low: assert property ((!ctl_sh[1] && mod_sh >= modsel_pkg::MOD_FIRST_RSVD) [*3]
    |=> modulated_out == $past(low_carrier)) else $error("reserved modulation code not low");
  a_sync_hold: assert property (ctl_sh == 2'h2 && $past(ctl_sh) == 2'h3 && lvl_mode && capture_compare_output[0]
    |=> modulated_out) else $error("switched low before high carrier fell");
endmodule

// ---- tb/periph_model.sv ----
// partner: on-chip peripheral outputs and pin routing that feed the selectors
// assumes: the bench changes the level vector just after a rising clock edge
`timescale 1ns/100ps
module periph_model (
  input wire logic [30:0] lv,
  output logic mpin,
  output logic cpin,
  output logic sysclk,
  output logic fast,
  output logic tx,
  output logic sdata,
  output logic spi,
  output logic [3:0] capt,
  output logic [8:0] pwm,
  output logic [3:0] cells,
  output logic [5:0] cmp,
  output logic lowc
);
  // static levels instead of toggling clocks, so every selection is observable
  assign {lowc, cmp, cells, pwm, capt, spi, sdata, tx, fast, sysclk, cpin, mpin} = lv;
endmodule

// ---- tb/modulator_source_select_bench.sv ----
// bench: register access, sweep of both selectors and carrier switching
// assumes: package, interface, design, partner model and checker compiled first
`timescale 1ns/100ps
module modulator_source_select_bench;
  typedef struct {logic [31:0] m; logic [31:0] v;} note_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic por_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [30:0] lv = 31'h0;
  logic clk_en = 1'b1;
  logic [31:0] rnd = 32'h2e24e4e4;
  logic lvl = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  note_t notes[$];
  // lane of the level vector per code; -2 software level, -1 reserved
  int mod_map[32] = '{0, -2, 4, 5, 6, 7, 8, 9, 15, 11, 12, 16, 17, 13, 14, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27,
    28, 29, -1, -1, -1, -1, -1};
  int car_map[32] = '{1, 2, 3, 7, 8, 9, 10, 11, 12, 16, 17, 13, 14, 18, 19, 20, 21, 22, 23, -1, -1, -1, -1, -1, -1,
    -1, -1, -1, -1, -1, -1, -1};
  wire mpin, cpin, sysclk, fast, tx, sdata, spi, lowc, mout;
  wire [3:0] capt;
  wire [3:0] cells;
  wire [8:0] pwm;
  wire [5:0] cmp;
  periph_model periph_model_i (.lv(lv), .mpin(mpin), .cpin(cpin), .sysclk(sysclk), .fast(fast), .tx(tx),
    .sdata(sdata), .spi(spi), .capt(capt), .pwm(pwm), .cells(cells), .cmp(cmp), .lowc(lowc));
  modulator_source_select modulator_source_select_i (.ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n),
    .clk_en(clk_en), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .modulation_pin_route(mpin),
    .carrier_pin_route(cpin), .system_clock_source(sysclk), .fast_internal_oscillator(fast),
    .serial_transmit_output(tx), .usart_sync_data(sdata), .spi_data_output(spi), .capture_compare_output(capt),
    .pwm_output(pwm), .logic_cell_output(cells), .synchronized_comparator_output(cmp), .low_carrier(lowc),
    .modulated_out(mout));
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pick(input int idx);
    if (idx == -2) return lvl;
    if (idx < 0) return 1'b0;
    return lv[idx];
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t readdata %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle edge first, so a release and a new request never share a time step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest) begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    notes.push_back(note_t'{m, v});
    repeat (2) @(posedge ref_clk);
    bus(1'b0, a, 32'h0);
  endtask
  // read data taken at the edge where waitrequest is sampled low
  always @(posedge ref_clk) begin
    if (read && !waitrequest && notes.size() > 0) begin
      note_t e;
      e = notes.pop_front();
      check(readdata & e.m, e.v);
    end
  end
  initial begin
    int c;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    rd(4'h8, 32'hffffffff, 32'h0);
    rd(4'h0, 32'hffffffff, 32'h0);
    bus(1'b1, 4'h0, 32'hffffffff);
    rd(4'h0, 32'hffffffff, 32'h1f);
    bus(1'b1, 4'h4, 32'hffffffe5);
    rd(4'h4, 32'hffffffff, 32'h5);
    rd(4'h2, 32'hffffffff, 32'h0);
    byteenable <= 4'h0;
    bus(1'b1, 4'h4, 32'h9);
    byteenable <= 4'hf;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(4'h4, 32'hffffffff, 32'h5);
    for (c = 0; c < 32; c++) begin
      rnd = lfsr(rnd);
      lv <= rnd[30:0];
      lvl = rnd[31];
      bus(1'b1, 4'h8, {31'h0, lvl});
      bus(1'b1, 4'h0, 32'(c));
      bus(1'b1, 4'h4, 32'(c));
      rd(4'hc, 32'h6, {29'h0, pick(car_map[c]), pick(mod_map[c]), 1'b0});
    end
    // enable drops just before the request is taken: the write must wait, not vanish
    fork
      bus(1'b1, 4'h0, 32'h1b);
      begin
        repeat (2) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    rd(4'h0, 32'hffffffff, 32'h1b);
    lv <= 31'h80;
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b1, 4'h8, 32'h1);
    rd(4'hc, 32'h5, 32'h5);
    bus(1'b1, 4'h8, 32'h0);
    rd(4'hc, 32'h9, 32'h0);
    bus(1'b1, 4'h8, 32'h3);
    bus(1'b1, 4'h8, 32'h2);
    rd(4'hc, 32'h9, 32'h9);
    lv <= 31'h0;
    rd(4'hc, 32'h9, 32'h0);
    @(posedge ref_clk);
    // a read whose note was never taken counts as a mismatch
    if (notes.size() != 0) begin
      miscompares++;
    end
    report_and_stop;
  end
endmodule
bind modulator_source_select modulator_source_select_checker modulator_source_select_checker_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n), .clk_en(clk_en), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .capture_compare_output(capture_compare_output), .low_carrier(low_carrier),
  .modulated_out(modulated_out));
